// >>> shared/isd_defines.svh
// constants for the instruction subset decode and execute block
// Notes on behaviour
// - toggle bit b of f, flags kept
// - a=0 access bank, a=1 bank select bank
// - a=0, extended on, f<=5Fh uses indexed offset
// - overflow branch taken only when overflow set
// - zero branch taken only when zero set
// - taken branch target is pc+2+2n
// - branch one cycle, taken two with flush
// - call is two words, k low then high
// - call pushes pc+4, loads target into pc
// - s=1 copies w, status, bank to shadows
// - call two cycles, Q2 Q3 Q4 steps
// - clear writes zero to f, sets zero
// - clear watchdog resets counter, sets both flags
// - complement inverts f, updates negative and zero
// - d=0 result to w, d=1 to f
`ifndef ISD_DEFINES_SVH
`define ISD_DEFINES_SVH
`define ISD_IDX_LIMIT 8'h5F
`define ISD_ACCESS_SPLIT 8'h60
`define ISD_SFR_BANK 4'hF
`define ISD_PC_RESET 21'h000000
`define ISD_FLAG_C 0
`define ISD_FLAG_Z 2
`define ISD_FLAG_OV 3
`define ISD_FLAG_N 4
`define ISD_PC_STEP 21'h000002
`define ISD_CALL_RET 21'h000004
`endif

// >>> shared/isd_pkg.sv
// types for the instruction subset decode and execute block
package isd_pkg;
  typedef enum logic [3:0] {
    ISD_Q1 = 4'b0001,
    ISD_Q2 = 4'b0010,
    ISD_Q3 = 4'b0100,
    ISD_Q4 = 4'b1000
  } isd_phase_e;
  typedef enum logic [7:0] {
    ISD_OP_NONE = 8'b00000001,
    ISD_OP_TOGGLE = 8'b00000010,
    ISD_OP_BOV = 8'b00000100,
    ISD_OP_BZ = 8'b00001000,
    ISD_OP_CALL = 8'b00010000,
    ISD_OP_CLR = 8'b00100000,
    ISD_OP_WDT = 8'b01000000,
    ISD_OP_COMPLEMENT_REGISTER_OP = 8'b10000000
  } isd_op_e;
endpackage : isd_pkg

// >>> src/isd_decode.sv
// combinational opcode classifier for the supported subset
module isd_decode (
  input wire logic [15:0] word,
  output isd_pkg::isd_op_e op
);
  always_comb begin
    op = isd_pkg::ISD_OP_NONE;
    if (word[15:12] == 4'h7) begin
      op = isd_pkg::ISD_OP_TOGGLE;
    end else if (word[15:8] == 8'hE4) begin
      op = isd_pkg::ISD_OP_BOV;
    end else if (word[15:8] == 8'hE0) begin
      op = isd_pkg::ISD_OP_BZ;
    end else if (word[15:9] == 7'h76) begin
      op = isd_pkg::ISD_OP_CALL;
    end else if (word[15:9] == 7'h35) begin
      op = isd_pkg::ISD_OP_CLR;
    end else if (word == 16'h0004) begin
      op = isd_pkg::ISD_OP_WDT;
    end else if (word[15:10] == 6'h07) begin
      op = isd_pkg::ISD_OP_COMPLEMENT_REGISTER_OP;
    end
  end
endmodule : isd_decode

// >>> src/isd_core.sv
// quarter-phase execution of the supported instruction subset
`include "isd_defines.svh"
module isd_core #(
  parameter int PC_W = 21
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] next_word,
  input wire logic instr_valid,
  input wire logic ext_set_en,
  input wire logic [7:0] fsr2_base,
  input wire logic [7:0] data_rd,
  output logic [11:0] data_addr,
  output logic [7:0] data_wr,
  output logic data_we,
  output logic [7:0] working_reg,
  output logic [7:0] status_reg,
  output logic [3:0] bank_select_reg,
  output logic [7:0] working_shadow,
  output logic [7:0] status_shadow,
  output logic [3:0] bank_select_shadow,
  output logic [PC_W-1:0] pc,
  output logic [PC_W-1:0] top_of_stack,
  output logic push_stb,
  output logic wdt_clear,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic instr_done,
  output logic flushing
);
  isd_pkg::isd_phase_e ph_reg, ph_next;
  isd_pkg::isd_op_e op_dec, op_reg, op_next;
  logic [15:0] iw_reg, iw_next;
  logic [7:0] val_reg, val_next;
  logic flush_reg, flush_next;
  logic [11:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic we_reg, we_next;
  logic [7:0] w_reg, w_next, st_reg, st_next, ws_reg, ws_next, ss_reg, ss_next;
  logic [3:0] bsr_reg, bsr_next, bs_reg, bs_next;
  logic [PC_W-1:0] pc_reg, pc_next, tos_reg, tos_next;
  logic push_reg, push_next, wclr_reg, wclr_next;
  logic to_reg, to_next, pd_reg, pd_next, done_reg, done_next;
  logic [7:0] f;
  logic [11:0] ea;
  logic [7:0] res;
  logic take;
  logic [PC_W-1:0] boff;

  isd_decode u_dec (
    .word(instr_word),
    .op(op_dec)
  );

  assign f = iw_reg[7:0];
  assign boff = PC_W'({{(PC_W-9){iw_reg[7]}}, iw_reg[7:0], 1'b0});
  assign take = (op_reg == isd_pkg::ISD_OP_BOV && st_reg[`ISD_FLAG_OV]) ||
    (op_reg == isd_pkg::ISD_OP_BZ && st_reg[`ISD_FLAG_Z]);

  always_comb begin
    ea = {bsr_reg, f};
    if (!iw_reg[8]) begin
      if (ext_set_en && f <= `ISD_IDX_LIMIT) begin
        ea = {4'h0, 8'(fsr2_base + f)};
      end else if (f < `ISD_ACCESS_SPLIT) begin
        ea = {4'h0, f};
      end else begin
        ea = {`ISD_SFR_BANK, f};
      end
    end
  end

  always_comb begin
    ph_next = ph_reg;
    op_next = op_reg;
    iw_next = iw_reg;
    val_next = val_reg;
    flush_next = flush_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    we_next = 1'b0;
    w_next = w_reg;
    st_next = st_reg;
    bsr_next = bsr_reg;
    ws_next = ws_reg;
    ss_next = ss_reg;
    bs_next = bs_reg;
    pc_next = pc_reg;
    tos_next = tos_reg;
    push_next = 1'b0;
    wclr_next = 1'b0;
    to_next = to_reg;
    pd_next = pd_reg;
    done_next = 1'b0;
    res = ~val_reg;
    case (ph_reg)
      isd_pkg::ISD_Q1: begin
        if (flush_reg) begin
          op_next = isd_pkg::ISD_OP_NONE;
          ph_next = isd_pkg::ISD_Q2;
        end else if (instr_valid) begin
          op_next = op_dec;
          iw_next = instr_word;
          ph_next = isd_pkg::ISD_Q2;
        end
      end
      isd_pkg::ISD_Q2: begin
        addr_next = ea;
        val_next = data_rd;
        if (op_reg == isd_pkg::ISD_OP_CALL) begin
          val_next = iw_reg[7:0];
        end
        ph_next = isd_pkg::ISD_Q3;
      end
      isd_pkg::ISD_Q3: begin
        if (!flush_reg) begin
          pc_next = PC_W'(pc_reg + `ISD_PC_STEP);
        end
        case (op_reg)
          isd_pkg::ISD_OP_TOGGLE: begin
            wdata_next = val_reg ^ (8'h01 << iw_reg[11:9]);
          end
          isd_pkg::ISD_OP_CLR: begin
            wdata_next = 8'h00;
          end
          isd_pkg::ISD_OP_COMPLEMENT_REGISTER_OP: begin
            wdata_next = res;
          end
          isd_pkg::ISD_OP_CALL: begin
            tos_next = PC_W'(pc_reg + `ISD_CALL_RET);
            push_next = 1'b1;
            if (iw_reg[8]) begin
              ws_next = w_reg;
              ss_next = st_reg;
              bs_next = bsr_reg;
            end
          end
          isd_pkg::ISD_OP_WDT: begin
            wclr_next = 1'b1;
            to_next = 1'b1;
            pd_next = 1'b1;
          end
          default: begin
          end
        endcase
        ph_next = isd_pkg::ISD_Q4;
      end
      isd_pkg::ISD_Q4: begin
        flush_next = 1'b0;
        done_next = 1'b1;
        case (op_reg)
          isd_pkg::ISD_OP_TOGGLE: begin
            we_next = 1'b1;
          end
          isd_pkg::ISD_OP_CLR: begin
            we_next = 1'b1;
            st_next[`ISD_FLAG_Z] = 1'b1;
          end
          isd_pkg::ISD_OP_COMPLEMENT_REGISTER_OP: begin
            if (iw_reg[9]) begin
              we_next = 1'b1;
            end else begin
              w_next = wdata_reg;
            end
            st_next[`ISD_FLAG_N] = wdata_reg[7];
            st_next[`ISD_FLAG_Z] = (wdata_reg == 8'h00);
          end
          isd_pkg::ISD_OP_BOV, isd_pkg::ISD_OP_BZ: begin
            if (take) begin
              pc_next = PC_W'(pc_reg + boff);
              flush_next = 1'b1;
            end
          end
          isd_pkg::ISD_OP_CALL: begin
            pc_next = PC_W'({next_word[11:0], val_reg, 1'b0});
            flush_next = 1'b1;
          end
          default: begin
          end
        endcase
        ph_next = isd_pkg::ISD_Q1;
      end
      default: begin
        ph_next = isd_pkg::ISD_Q1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ph_reg <= isd_pkg::ISD_Q1;
      op_reg <= isd_pkg::ISD_OP_NONE;
      iw_reg <= 16'h0000;
      val_reg <= 8'h00;
      flush_reg <= 1'b0;
      addr_reg <= 12'h000;
      wdata_reg <= 8'h00;
      we_reg <= 1'b0;
      w_reg <= 8'h00;
      st_reg <= 8'h00;
      bsr_reg <= 4'h0;
      ws_reg <= 8'h00;
      ss_reg <= 8'h00;
      bs_reg <= 4'h0;
      pc_reg <= PC_W'(`ISD_PC_RESET);
      tos_reg <= PC_W'(`ISD_PC_RESET);
      push_reg <= 1'b0;
      wclr_reg <= 1'b0;
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      ph_reg <= ph_next;
      op_reg <= op_next;
      iw_reg <= iw_next;
      val_reg <= val_next;
      flush_reg <= flush_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      we_reg <= we_next;
      w_reg <= w_next;
      st_reg <= st_next;
      bsr_reg <= bsr_next;
      ws_reg <= ws_next;
      ss_reg <= ss_next;
      bs_reg <= bs_next;
      pc_reg <= pc_next;
      tos_reg <= tos_next;
      push_reg <= push_next;
      wclr_reg <= wclr_next;
      to_reg <= to_next;
      pd_reg <= pd_next;
      done_reg <= done_next;
    end
  end

  assign data_addr = addr_reg;
  assign data_wr = wdata_reg;
  assign data_we = we_reg;
  assign working_reg = w_reg;
  assign status_reg = st_reg;
  assign bank_select_reg = bsr_reg;
  assign working_shadow = ws_reg;
  assign status_shadow = ss_reg;
  assign bank_select_shadow = bs_reg;
  assign pc = pc_reg;
  assign top_of_stack = tos_reg;
  assign push_stb = push_reg;
  assign wdt_clear = wclr_reg;
  assign timeout_flag_n = to_reg;
  assign powerdown_flag_n = pd_reg;
  assign instr_done = done_reg;
  assign flushing = flush_reg;

  sequence s_q4_branch_taken;
    ph_reg == isd_pkg::ISD_Q4 && take;
  endsequence
  sequence s_q4_branch_skip;
    ph_reg == isd_pkg::ISD_Q4 && !take &&
      (op_reg == isd_pkg::ISD_OP_BOV || op_reg == isd_pkg::ISD_OP_BZ);
  endsequence
  sequence s_flush_q3;
    ph_reg == isd_pkg::ISD_Q3 && flush_reg;
  endsequence

  AST_BRANCH_TARGET: assert property (@(posedge clock) disable iff (rst)
    s_q4_branch_taken |=> pc_reg == PC_W'($past(pc_reg) + $past(boff)))
    else $error("taken branch target wrong");
  AST_BRANCH_FLUSH: assert property (@(posedge clock) disable iff (rst)
    s_q4_branch_taken |=> flush_reg ##1 op_reg == isd_pkg::ISD_OP_NONE)
    else $error("taken branch not flushed");
  AST_BRANCH_SKIP: assert property (@(posedge clock) disable iff (rst)
    s_q4_branch_skip |=> !flush_reg && $stable(pc_reg))
    else $error("untaken branch changed flow");
  AST_CALL_PUSH: assert property (@(posedge clock) disable iff (rst)
    push_reg |-> tos_reg == PC_W'($past(pc_reg) + `ISD_CALL_RET))
    else $error("call pushed wrong return");
  AST_CALL_PC: assert property (@(posedge clock) disable iff (rst)
    push_reg |=> pc_reg[8:1] == $past(val_reg) ##1 flush_reg)
    else $error("call target or flush wrong");
  AST_CLR_ZERO: assert property (@(posedge clock) disable iff (rst)
    ph_reg == isd_pkg::ISD_Q4 && op_reg == isd_pkg::ISD_OP_CLR |=>
      data_we && data_wr == 8'h00 && st_reg[`ISD_FLAG_Z])
    else $error("clear did not zero");
  AST_WDT_FLAGS: assert property (@(posedge clock) disable iff (rst)
    wclr_reg |-> to_reg && pd_reg)
    else $error("watchdog flags not set");
  AST_COMPLEMENT_REGISTER_OP_DEST: assert property (@(posedge clock) disable iff (rst)
    ph_reg == isd_pkg::ISD_Q4 && op_reg == isd_pkg::ISD_OP_COMPLEMENT_REGISTER_OP && !iw_reg[9] |=>
      !data_we && w_reg == ~$past(val_reg))
    else $error("complement to w wrong");
  AST_FLAGS_KEPT: assert property (@(posedge clock) disable iff (rst)
    ph_reg == isd_pkg::ISD_Q4 && (op_reg == isd_pkg::ISD_OP_TOGGLE ||
      op_reg == isd_pkg::ISD_OP_CALL || op_reg == isd_pkg::ISD_OP_BZ ||
      op_reg == isd_pkg::ISD_OP_BOV) |=> $stable(st_reg))
    else $error("status changed");
  AST_FLUSH_PC_HOLD: assert property (@(posedge clock) disable iff (rst)
    s_flush_q3 |=> $stable(pc_reg) && !data_we && !push_reg)
    else $error("flush cycle changed state");
  AST_TOGGLE_ONE_BIT: assert property (@(posedge clock) disable iff (rst)
    ph_reg == isd_pkg::ISD_Q4 && op_reg == isd_pkg::ISD_OP_TOGGLE |=>
      data_we && $countones(data_wr ^ $past(val_reg)) == 1)
    else $error("toggle did not flip one bit");
  AST_CALL_SHADOW: assert property (@(posedge clock) disable iff (rst)
    push_reg |-> (iw_reg[8] ? (ws_reg == $past(w_reg) && ss_reg == $past(st_reg) &&
      bs_reg == $past(bsr_reg)) : ($stable(ws_reg) && $stable(ss_reg) && $stable(bs_reg))))
    else $error("call shadow copy wrong");
endmodule : isd_core

// >>> test/isd_core_tb_top.sv
// self-checking bench for the instruction subset core
module isd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic [15:0] next_word = 16'h0000;
  logic instr_valid = 1'b0;
  logic ext_set_en = 1'b0;
  logic [7:0] fsr2_base = 8'h00;
  logic [7:0] data_rd = 8'h00;
  logic [11:0] data_addr;
  logic [7:0] data_wr, working_reg, status_reg, working_shadow, status_shadow;
  logic [3:0] bank_select_reg, bank_select_shadow;
  logic [20:0] pc, top_of_stack, pc_old;
  logic data_we, push_stb, wdt_clear, timeout_flag_n, powerdown_flag_n, instr_done, flushing;
  logic push_seen, wdt_seen;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;

  isd_core #(.PC_W(21)) DUT (.clock(clock), .rst(rst), .instr_word(instr_word),
    .next_word(next_word), .instr_valid(instr_valid), .ext_set_en(ext_set_en),
    .fsr2_base(fsr2_base), .data_rd(data_rd), .data_addr(data_addr), .data_wr(data_wr),
    .data_we(data_we), .working_reg(working_reg), .status_reg(status_reg),
    .bank_select_reg(bank_select_reg), .working_shadow(working_shadow),
    .status_shadow(status_shadow), .bank_select_shadow(bank_select_shadow), .pc(pc),
    .top_of_stack(top_of_stack), .push_stb(push_stb), .wdt_clear(wdt_clear),
    .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
    .instr_done(instr_done), .flushing(flushing));

  initial begin
    forever #50 clock = ~clock;
  end

  // hang guard: the whole run needs under a hundred cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task chk_val(input string nm, input logic [20:0] exp, input logic [20:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val

  task chk_bit(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  // one instruction cycle: take at Q1, sample just after each of the last three quarter edges
  task exec(input logic [15:0] w, input logic [15:0] nw, input logic [7:0] rd);
    pc_old = pc;
    push_seen = 1'b0;
    wdt_seen = 1'b0;
    @(posedge clock);
    instr_word <= w;
    next_word <= nw;
    data_rd <= rd;
    instr_valid <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    repeat (3) begin
      @(posedge clock);
      #1;
      push_seen = push_seen | push_stb;
      wdt_seen = wdt_seen | wdt_clear;
    end
  endtask : exec

  // check the flush cycle and let it run out
  task settle(input logic fl);
    chk_bit("flushing", fl, flushing);
    pc_old = pc;
    if (fl) begin
      repeat (4) @(posedge clock);
      #1;
    end
    chk_val("pc_hold", pc_old, pc);
  endtask : settle

  task t_reset();
    chk_val("pc", 21'h000000, pc);
    chk_bit("timeout_flag_n", 1'b1, timeout_flag_n);
  endtask : t_reset

  task t_toggle();
    exec(16'h7820, 16'h0000, 8'h75);
    chk_val("data_wr", 21'h65, data_wr);
    chk_bit("data_we", 1'b1, data_we);
    chk_val("data_addr", 21'h020, data_addr);
    chk_val("status", 21'h00, status_reg);
    chk_val("pc", pc_old + 21'h000002, pc);
    settle(1'b0);
  endtask : t_toggle

  task t_clear();
    exec(16'h6A80, 16'h0000, 8'h5A);
    chk_val("data_wr", 21'h00, data_wr);
    chk_val("data_addr", 21'hF80, data_addr);
    chk_val("status", 21'h04, status_reg);
    chk_bit("instr_done", 1'b1, instr_done);
  endtask : t_clear

  task t_bz_taken();
    exec(16'hE080, 16'h0000, 8'h00);
    chk_val("pc", pc_old + 21'h000002 - 21'h000100, pc);
    chk_val("status", 21'h04, status_reg);
    chk_bit("data_we", 1'b0, data_we);
    settle(1'b1);
  endtask : t_bz_taken

  task t_comp_w();
    exec(16'h1D13, 16'h0000, 8'h13);
    chk_val("working", 21'hEC, working_reg);
    chk_bit("data_we", 1'b0, data_we);
    chk_val("status", 21'h10, status_reg);
    chk_val("data_addr", 21'h013, data_addr);
  endtask : t_comp_w

  task t_not_taken();
    exec(16'hE07F, 16'h0000, 8'h00);
    chk_val("pc", pc_old + 21'h000002, pc);
    settle(1'b0);
    exec(16'hE405, 16'h0000, 8'h00);
    chk_val("pc", pc_old + 21'h000002, pc);
    settle(1'b0);
  endtask : t_not_taken

  task t_comp_idx();
    @(posedge clock);
    ext_set_en <= 1'b1;
    fsr2_base <= 8'h30;
    exec(16'h1E10, 16'h0000, 8'hFF);
    chk_val("data_wr", 21'h00, data_wr);
    chk_bit("data_we", 1'b1, data_we);
    chk_val("data_addr", 21'h040, data_addr);
    chk_val("status", 21'h04, status_reg);
  endtask : t_comp_idx

  task t_call();
    exec(16'hEC34, 16'hF5A2, 8'h00);
    chk_val("top_of_stack", pc_old + 21'h000004, top_of_stack);
    chk_val("pc", 21'h0B4468, pc);
    chk_bit("push", 1'b1, push_seen);
    chk_val("working_shadow", 21'h00, working_shadow);
    settle(1'b1);
    exec(16'hED01, 16'hF000, 8'h00);
    chk_val("pc", 21'h000002, pc);
    chk_val("top_of_stack", 21'h0B446C, top_of_stack);
    chk_val("working_shadow", 21'hEC, working_shadow);
    chk_val("status_shadow", 21'h04, status_shadow);
    chk_val("bank_select_shadow", 21'h0, bank_select_shadow);
    chk_val("status", 21'h04, status_reg);
    settle(1'b1);
  endtask : t_call

  task t_wdt();
    exec(16'h0004, 16'h0000, 8'h00);
    chk_bit("wdt_clear", 1'b1, wdt_seen);
    chk_bit("timeout_flag_n", 1'b1, timeout_flag_n);
    chk_bit("powerdown_flag_n", 1'b1, powerdown_flag_n);
    chk_val("pc", pc_old + 21'h000002, pc);
  endtask : t_wdt

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset();
    t_toggle();
    t_clear();
    t_bz_taken();
    t_comp_w();
    t_not_taken();
    t_comp_idx();
    t_call();
    t_wdt();
    print_verdict();
  end
endmodule : isd_core_tb_top
